/* File: ncobhs_pkg.sv */
// constants shared by the nco bank with hop select
package ncobhs_pkg;

  localparam int NCOBHS_NUM_NCO = 4;
  localparam int NCOBHS_ADDR_W  = 8;
  localparam int NCOBHS_LUT_W   = 8;
  localparam int NCOBHS_RDIV_W  = 16;
  localparam int NCOBHS_RDIV_SHIFT = 6;
  localparam int NCOBHS_RAT_W   = NCOBHS_RDIV_W + NCOBHS_RDIV_SHIFT;

  localparam logic [7:0] NCOBHS_CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] NCOBHS_RDIV_OFFSET   = 8'h04;
  localparam logic [7:0] NCOBHS_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] NCOBHS_FREQ_A_BASE   = 8'h40;
  localparam logic [7:0] NCOBHS_FREQ_B_BASE   = 8'h50;
  localparam logic [7:0] NCOBHS_PHASE_A_BASE  = 8'h60;
  localparam logic [7:0] NCOBHS_PHASE_B_BASE  = 8'h70;

  localparam int NCOBHS_CTRL_SRC_BIT       = 0;
  localparam int NCOBHS_CTRL_SEL_A_LSB     = 1;
  localparam int NCOBHS_CTRL_SEL_B_LSB     = 3;
  localparam int NCOBHS_CTRL_SYNC_INIT_BIT = 5;
  localparam int NCOBHS_CTRL_SYNC_NEXT_BIT = 6;

  localparam logic        NCOBHS_SRC_PINS    = 1'b1;
  localparam logic        NCOBHS_SRC_RESET   = 1'b0;
  localparam logic [1:0]  NCOBHS_SEL_RESET   = 2'h0;
  localparam logic [15:0] NCOBHS_RDIV_BASIC  = 16'h0000;
  localparam logic [31:0] NCOBHS_FREQ_RESET  = 32'h00000000;
  localparam logic [15:0] NCOBHS_PHASE_RESET = 16'h0000;

  localparam logic [1:0] NCOBHS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] NCOBHS_RESP_SLVERR = 2'h2;

  // quarter wave of sine, 16 points, amplitude 127
  localparam logic [7:0] NCOBHS_SIN_LUT [16] = '{
    8'h00, 8'h0C, 8'h19, 8'h25, 8'h31, 8'h3C, 8'h47, 8'h51,
    8'h5A, 8'h62, 8'h6A, 8'h70, 8'h75, 8'h7A, 8'h7D, 8'h7E
  };

endpackage

/* File: ncobhs_sync2.sv */
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module ncobhs_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

/* File: ncobhs_phase_acc.sv */
// one free-running phase accumulator with phase offset
`timescale 1ns/1ps
module ncobhs_phase_acc (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_restart,
  input  wire logic [31:0] i_freq_word,
  input  wire logic [15:0] i_phase_offset,
  output logic      [31:0] o_phase
);

  logic [31:0] acc;

  // runs every sample whether selected or not
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      acc <= 32'h00000000;
    end else if (i_restart) begin
      acc <= 32'h00000000;
    end else begin
      acc <= acc + i_freq_word;
    end
  end

  // offset is left-justified into the 32-bit phase
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_phase <= 32'h00000000;
    end else begin
      o_phase <= acc + {i_phase_offset, 16'h0000};
    end
  end

endmodule

/* File: ncobhs_top.sv */
// nco bank with fast hop select for two down-converter channels
//
// Notes on behaviour
// - four independent ncos per channel, each channel with its own two select pins
// - unselected accumulators keep running so re-selection keeps continuous phase
// - in pin mode a change on a channel's select pins switches its nco
// - select pins are asynchronous; hop sample is not repeatable
// - source bit 1 selects by pins, 0 (default) by register field
// - two-bit value, upper bit msb, picks nco 0 to 3; other source ignored
// - each setting drives its own accumulator with own frequency and offset
// - divider zero: 32-bit word, fout = word * 2^-32 * fs
// - rewriting a running frequency word leaves phase undefined until resync
// - divider nonzero: accumulator wraps every 64 times divider samples
// - 16-bit offset placed in upper half and added to accumulator
// - phase reset on link init or sysref, chosen by two control bits
// - link sync input triggers nco sync also in 64b/66b modes
// - with link-init sync enabled, sync deassertion aligns all ncos
// - armed next-sysref bit makes one following sysref pulse align ncos
// - selected nco output multiplies the real sample stream
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module ncobhs_top #(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset,
  input  wire logic [7:0]            i_axi_awaddr,
  input  wire logic                  i_axi_awvalid,
  output logic                       o_axi_awready,
  input  wire logic [31:0]           i_axi_wdata,
  input  wire logic [3:0]            i_axi_wstrb,
  input  wire logic                  i_axi_wvalid,
  output logic                       o_axi_wready,
  output logic [1:0]                 o_axi_bresp,
  output logic                       o_axi_bvalid,
  input  wire logic                  i_axi_bready,
  input  wire logic [7:0]            i_axi_araddr,
  input  wire logic                  i_axi_arvalid,
  output logic                       o_axi_arready,
  output logic [31:0]                o_axi_rdata,
  output logic [1:0]                 o_axi_rresp,
  output logic                       o_axi_rvalid,
  input  wire logic                  i_axi_rready,
  input  wire logic                  i_chan_a_hop_sel_bit0,
  input  wire logic                  i_chan_a_hop_sel_bit1,
  input  wire logic                  i_chan_b_hop_sel_bit0,
  input  wire logic                  i_chan_b_hop_sel_bit1,
  input  wire logic                  i_sysref,
  input  wire logic                  i_link_sync_n,
  input  wire logic                  i_link_enable,
  input  wire logic [SAMPLE_W-1:0]   i_sample,
  output logic signed [SAMPLE_W+7:0] o_chan_a_i,
  output logic signed [SAMPLE_W+7:0] o_chan_a_q,
  output logic signed [SAMPLE_W+7:0] o_chan_b_i,
  output logic signed [SAMPLE_W+7:0] o_chan_b_q,
  output logic [1:0]                 o_chan_a_active,
  output logic [1:0]                 o_chan_b_active,
  output logic                       o_nco_sync
);

  localparam int PROD_W = SAMPLE_W + ncobhs_pkg::NCOBHS_LUT_W;
  localparam int NNCO   = ncobhs_pkg::NCOBHS_NUM_NCO;
  localparam int RAT_W  = ncobhs_pkg::NCOBHS_RAT_W;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  logic [5:0]        pins_s;
  logic              sysref_s;
  logic              sync_n_s;
  logic [1:0]        pin_sel_a;
  logic [1:0]        pin_sel_b;
  logic              sysref_q;
  logic              sync_n_q;
  logic              hop_select_source;
  logic [1:0]        chan_a_soft_select;
  logic [1:0]        chan_b_soft_select;
  logic              sync_on_link_init;
  logic              sync_on_next_sysref;
  logic [15:0]       rational_step_divider;
  logic [31:0]       chan_a_freq_word [NNCO];
  logic [31:0]       chan_b_freq_word [NNCO];
  logic [15:0]       chan_a_phase_offset [NNCO];
  logic [15:0]       chan_b_phase_offset [NNCO];
  logic [31:0]       acc_phase_a [NNCO];
  logic [31:0]       acc_phase_b [NNCO];
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_go;
  logic              wr_ctrl;
  logic [31:0]       rd_word;
  logic [RAT_W-1:0]  rat_cnt;
  logic [RAT_W-1:0]  rat_top;
  logic              rat_wrap;
  logic              link_fire;
  logic              sysref_fire;
  logic              sync_fire;
  logic              acc_restart;
  logic [7:0]        sync_count;
  logic [5:0]        lut_a;
  logic [5:0]        lut_b;

  // pins come from outside the clock domain
  ncobhs_sync2 #(
    .WIDTH (6)
  ) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_async   ({i_sysref, i_link_sync_n, i_chan_b_hop_sel_bit1, i_chan_b_hop_sel_bit0,
                 i_chan_a_hop_sel_bit1, i_chan_a_hop_sel_bit0}),
    .o_sync    (pins_s)
  );

  assign pin_sel_a = pins_s[1:0];
  assign pin_sel_b = pins_s[3:2];
  assign sync_n_s  = pins_s[4];
  assign sysref_s  = pins_s[5];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[7:4] == 4'h0 && a[3:2] != 2'h3) || (a[7:6] == 2'h1);
  endfunction

  function automatic logic signed [7:0] sin_lut(input logic [5:0] p);
    logic [3:0] idx;
    logic [7:0] mag;
    idx = p[4] ? 4'h0 - p[3:0] : p[3:0];
    mag = ncobhs_pkg::NCOBHS_SIN_LUT[idx];
    // the mirrored half must reach the peak, which the table itself does not hold
    if (p[4] && p[3:0] == 4'h0) begin
      mag = 8'h7F;
    end
    return p[5] ? -mag : mag;
  endfunction

  function automatic logic signed [PROD_W-1:0] mix(input logic signed [SAMPLE_W-1:0] s,
                                                  input logic signed [7:0] c);
    logic signed [PROD_W-1:0] se;
    logic signed [PROD_W-1:0] ce;
    se = s;
    ce = c;
    return se * ce;
  endfunction

  // write side: address and data taken in either order, response after both
  assign wr_go   = !o_axi_awready && !o_axi_wready && !o_axi_bvalid;
  assign wr_ctrl = wr_go && aw_addr == ncobhs_pkg::NCOBHS_CTRL_OFFSET && w_strb[0];

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_axi_awready <= 1'b1;
      o_axi_wready  <= 1'b1;
      o_axi_bvalid  <= 1'b0;
      o_axi_bresp   <= ncobhs_pkg::NCOBHS_RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else begin
      if (o_axi_awready && i_axi_awvalid) begin
        aw_addr       <= i_axi_awaddr;
        o_axi_awready <= 1'b0;
      end
      if (o_axi_wready && i_axi_wvalid) begin
        w_data       <= i_axi_wdata;
        w_strb       <= i_axi_wstrb;
        o_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        o_axi_bvalid <= 1'b1;
        o_axi_bresp  <= mapped(aw_addr) ? ncobhs_pkg::NCOBHS_RESP_OKAY
                                        : ncobhs_pkg::NCOBHS_RESP_SLVERR;
      end
      if (o_axi_bvalid && i_axi_bready) begin
        o_axi_bvalid  <= 1'b0;
        o_axi_awready <= 1'b1;
        o_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      hop_select_source     <= ncobhs_pkg::NCOBHS_SRC_RESET;
      chan_a_soft_select    <= ncobhs_pkg::NCOBHS_SEL_RESET;
      chan_b_soft_select    <= ncobhs_pkg::NCOBHS_SEL_RESET;
      sync_on_link_init     <= 1'b0;
      rational_step_divider <= ncobhs_pkg::NCOBHS_RDIV_BASIC;
    end else begin
      if (wr_ctrl) begin
        hop_select_source  <= w_data[ncobhs_pkg::NCOBHS_CTRL_SRC_BIT];
        chan_a_soft_select <= w_data[ncobhs_pkg::NCOBHS_CTRL_SEL_A_LSB +: 2];
        chan_b_soft_select <= w_data[ncobhs_pkg::NCOBHS_CTRL_SEL_B_LSB +: 2];
        sync_on_link_init  <= w_data[ncobhs_pkg::NCOBHS_CTRL_SYNC_INIT_BIT];
      end
      if (wr_go && aw_addr == ncobhs_pkg::NCOBHS_RDIV_OFFSET) begin
        rational_step_divider <= 16'(merge({16'h0000, rational_step_divider}, w_data, w_strb));
      end
    end
  end

  // a software write wins over the disarm that a sysref causes in the same cycle
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      sync_on_next_sysref <= 1'b0;
    end else if (wr_ctrl) begin
      sync_on_next_sysref <= w_data[ncobhs_pkg::NCOBHS_CTRL_SYNC_NEXT_BIT];
    end else if (sysref_fire) begin
      sync_on_next_sysref <= 1'b0;
    end
  end

  // frequency rewrites take effect at once; phase coherence needs a resync
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < NNCO; k++) begin
        chan_a_freq_word[k]    <= ncobhs_pkg::NCOBHS_FREQ_RESET;
        chan_b_freq_word[k]    <= ncobhs_pkg::NCOBHS_FREQ_RESET;
        chan_a_phase_offset[k] <= ncobhs_pkg::NCOBHS_PHASE_RESET;
        chan_b_phase_offset[k] <= ncobhs_pkg::NCOBHS_PHASE_RESET;
      end
    end else if (wr_go) begin
      for (int k = 0; k < NNCO; k++) begin
        if (aw_addr == ncobhs_pkg::NCOBHS_FREQ_A_BASE + 8'(4 * k)) begin
          chan_a_freq_word[k] <= merge(chan_a_freq_word[k], w_data, w_strb);
        end
        if (aw_addr == ncobhs_pkg::NCOBHS_FREQ_B_BASE + 8'(4 * k)) begin
          chan_b_freq_word[k] <= merge(chan_b_freq_word[k], w_data, w_strb);
        end
        if (aw_addr == ncobhs_pkg::NCOBHS_PHASE_A_BASE + 8'(4 * k)) begin
          chan_a_phase_offset[k] <= 16'(merge({16'h0000, chan_a_phase_offset[k]}, w_data,
                                              w_strb));
        end
        if (aw_addr == ncobhs_pkg::NCOBHS_PHASE_B_BASE + 8'(4 * k)) begin
          chan_b_phase_offset[k] <= 16'(merge({16'h0000, chan_b_phase_offset[k]}, w_data,
                                              w_strb));
        end
      end
    end
  end

  // read side: one-cycle answer
  always_comb begin
    rd_word = 32'h00000000;
    if (i_axi_araddr[7:2] == ncobhs_pkg::NCOBHS_CTRL_OFFSET[7:2]) begin
      rd_word = {25'h0000000, sync_on_next_sysref, sync_on_link_init, chan_b_soft_select,
                 chan_a_soft_select, hop_select_source};
    end else if (i_axi_araddr[7:2] == ncobhs_pkg::NCOBHS_RDIV_OFFSET[7:2]) begin
      rd_word = {16'h0000, rational_step_divider};
    end else if (i_axi_araddr[7:2] == ncobhs_pkg::NCOBHS_STATUS_OFFSET[7:2]) begin
      rd_word = {16'h0000, sync_count, 3'h0, sync_on_next_sysref, o_chan_b_active,
                 o_chan_a_active};
    end else if (i_axi_araddr[7:4] == ncobhs_pkg::NCOBHS_FREQ_A_BASE[7:4]) begin
      rd_word = chan_a_freq_word[i_axi_araddr[3:2]];
    end else if (i_axi_araddr[7:4] == ncobhs_pkg::NCOBHS_FREQ_B_BASE[7:4]) begin
      rd_word = chan_b_freq_word[i_axi_araddr[3:2]];
    end else if (i_axi_araddr[7:4] == ncobhs_pkg::NCOBHS_PHASE_A_BASE[7:4]) begin
      rd_word = {16'h0000, chan_a_phase_offset[i_axi_araddr[3:2]]};
    end else if (i_axi_araddr[7:4] == ncobhs_pkg::NCOBHS_PHASE_B_BASE[7:4]) begin
      rd_word = {16'h0000, chan_b_phase_offset[i_axi_araddr[3:2]]};
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_axi_arready <= 1'b1;
      o_axi_rvalid  <= 1'b0;
      o_axi_rdata   <= 32'h00000000;
      o_axi_rresp   <= ncobhs_pkg::NCOBHS_RESP_OKAY;
    end else if (o_axi_arready && i_axi_arvalid) begin
      o_axi_arready <= 1'b0;
      o_axi_rvalid  <= 1'b1;
      o_axi_rdata   <= rd_word;
      o_axi_rresp   <= mapped(i_axi_araddr) ? ncobhs_pkg::NCOBHS_RESP_OKAY
                                            : ncobhs_pkg::NCOBHS_RESP_SLVERR;
    end else if (o_axi_rvalid && i_axi_rready) begin
      o_axi_rvalid  <= 1'b0;
      o_axi_arready <= 1'b1;
    end
  end

  // sync triggers from link sync deassertion or an armed sysref edge
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      sysref_q <= 1'b0;
      sync_n_q <= 1'b0;
    end else begin
      sysref_q <= sysref_s;
      sync_n_q <= sync_n_s;
    end
  end

  // encoding mode is not looked at, so 64b/66b links trigger the same way
  assign link_fire   = sync_on_link_init && i_link_enable && sync_n_s && !sync_n_q;
  assign sysref_fire = sync_on_next_sysref && sysref_s && !sysref_q;
  assign sync_fire   = link_fire || sysref_fire;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_nco_sync <= 1'b0;
      sync_count <= 8'h00;
    end else begin
      o_nco_sync <= sync_fire;
      if (sync_fire) begin
        sync_count <= sync_count + 8'h01;
      end
    end
  end

  // rational mode: the whole bank restarts every 64 * divider samples
  assign rat_top  = {rational_step_divider, 6'h00} - 22'h000001;
  assign rat_wrap = rational_step_divider != ncobhs_pkg::NCOBHS_RDIV_BASIC
                    && rat_cnt == rat_top;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rat_cnt <= 22'h000000;
    end else if (sync_fire || rat_wrap
                 || rational_step_divider == ncobhs_pkg::NCOBHS_RDIV_BASIC) begin
      rat_cnt <= 22'h000000;
    end else begin
      rat_cnt <= rat_cnt + 22'h000001;
    end
  end

  assign acc_restart = sync_fire || rat_wrap;

  for (genvar g = 0; g < NNCO; g++) begin : g_nco
    ncobhs_phase_acc u_acc_a (
      .i_ref_clk      (i_ref_clk),
      .i_reset        (i_reset),
      .i_restart      (acc_restart),
      .i_freq_word    (chan_a_freq_word[g]),
      .i_phase_offset (chan_a_phase_offset[g]),
      .o_phase        (acc_phase_a[g])
    );
    ncobhs_phase_acc u_acc_b (
      .i_ref_clk      (i_ref_clk),
      .i_reset        (i_reset),
      .i_restart      (acc_restart),
      .i_freq_word    (chan_b_freq_word[g]),
      .i_phase_offset (chan_b_phase_offset[g]),
      .o_phase        (acc_phase_b[g])
    );
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_chan_a_active <= 2'h0;
      o_chan_b_active <= 2'h0;
    end else begin
      o_chan_a_active <= hop_select_source == ncobhs_pkg::NCOBHS_SRC_PINS ? pin_sel_a
                                                : chan_a_soft_select;
      o_chan_b_active <= hop_select_source == ncobhs_pkg::NCOBHS_SRC_PINS ? pin_sel_b
                                                : chan_b_soft_select;
    end
  end

  // only the top six phase bits address the table; spur level is traded for area
  assign lut_a = acc_phase_a[o_chan_a_active][31:26];
  assign lut_b = acc_phase_b[o_chan_b_active][31:26];

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_chan_a_i <= '0;
      o_chan_a_q <= '0;
      o_chan_b_i <= '0;
      o_chan_b_q <= '0;
    end else begin
      o_chan_a_i <= mix(i_sample, sin_lut(lut_a + 6'h10));
      o_chan_a_q <= -mix(i_sample, sin_lut(lut_a));
      o_chan_b_i <= mix(i_sample, sin_lut(lut_b + 6'h10));
      o_chan_b_q <= -mix(i_sample, sin_lut(lut_b));
    end
  end

  a_pin_select: assert property (
    (hop_select_source && $stable({i_chan_a_hop_sel_bit1, i_chan_a_hop_sel_bit0}))[*4]
    |-> o_chan_a_active == {i_chan_a_hop_sel_bit1, i_chan_a_hop_sel_bit0})
    else $error("channel a active nco does not follow pins");

  a_soft_select: assert property (
    (!hop_select_source && $stable(chan_b_soft_select))[*2]
    |-> o_chan_b_active == chan_b_soft_select)
    else $error("channel b active nco does not follow register field");

  a_acc_advance: assert property (
    (!acc_restart && $stable(chan_a_freq_word[3]) && $stable(chan_a_phase_offset[3]))
    ##1 $stable(chan_a_phase_offset[3])
    |=> acc_phase_a[3] - $past(acc_phase_a[3]) == $past(chan_a_freq_word[3], 2))
    else $error("accumulator did not advance by its frequency word");

  a_phase_offset: assert property (
    acc_restart |=> ##1 acc_phase_a[0] == {$past(chan_a_phase_offset[0]), 16'h0000})
    else $error("phase after restart is not the left-justified offset");

  a_rational_wrap: assert property (
    (rational_step_divider != 16'h0000 && rat_cnt == rat_top)
    |=> ##1 acc_phase_b[1] == {$past(chan_b_phase_offset[1]), 16'h0000})
    else $error("rational period end did not restart the accumulator");

  a_basic_no_wrap: assert property (
    rational_step_divider == 16'h0000 |=> rat_cnt == 22'h000000 && !rat_wrap)
    else $error("basic mode must not wrap the accumulator");

  a_sysref_sync: assert property (
    (sync_on_next_sysref && sysref_s && !sysref_q && !wr_ctrl)
    |=> o_nco_sync && !sync_on_next_sysref)
    else $error("armed sysref edge did not sync and disarm");

  a_link_sync: assert property (
    (sync_on_link_init && i_link_enable && sync_n_s && !sync_n_q) |=> o_nco_sync)
    else $error("link sync deassertion did not sync the ncos");

  a_no_trigger: assert property (
    (!sync_on_next_sysref && !sync_on_link_init) |=> !o_nco_sync)
    else $error("nco sync without an enabled trigger");

  a_mixer_zero: assert property (
    i_sample == '0 |=> o_chan_a_i == '0 && o_chan_a_q == '0)
    else $error("mixer output not zero for zero sample");

  a_bresp_hold: assert property (
    (o_axi_bvalid && !i_axi_bready) |=> o_axi_bvalid && $stable(o_axi_bresp))
    else $error("write response dropped before acceptance");

  c_pin_hop: cover property (hop_select_source && $changed(o_chan_a_active));
  c_sysref_sync: cover property (sysref_fire ##1 o_nco_sync);
  c_rational_wrap: cover property (rat_wrap);

endmodule

/* File: ncobhs_hop_ctrl.sv */
// far-side hop controller that drives the four select pins
`timescale 1ns/1ps
module ncobhs_hop_ctrl (
  input  wire logic [3:0] i_req,
  output logic      [3:0] o_pins
);
  // pins move a fixed 13 ns after each request, off the clock edges, so each hop lands on a fixed sample
  initial o_pins = 4'h0;
  always @(i_req) o_pins <= #13 i_req;
endmodule

/* File: tb.sv */
// self-checking bench for the nco bank with hop select
`timescale 1ns/1ps
module tb;
  logic clk, rst, awv, wv, bry, arv, rry, sysref, lsync_n, len;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] req, pins;
  logic [11:0] smp;
  logic [1:0] resp;
  wire logic awr, wr_r, bv, arr, rv, sync;
  wire logic [1:0] br, rr, act_a, act_b;
  wire logic [31:0] rdata;
  wire logic [19:0] ai, aq, bi, bq;
  int n_mismatch, checks, evt;
  ncobhs_hop_ctrl ncobhs_hop_ctrl_i (.i_req(req), .o_pins(pins));
  ncobhs_top ncobhs_top_i (.i_ref_clk(clk), .i_reset(rst), .i_axi_awaddr(awa),
    .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_wdata(wd), .i_axi_wstrb(4'hF),
    .i_axi_wvalid(wv), .o_axi_wready(wr_r), .o_axi_bresp(br), .o_axi_bvalid(bv),
    .i_axi_bready(bry), .i_axi_araddr(ara), .i_axi_arvalid(arv), .o_axi_arready(arr),
    .o_axi_rdata(rdata), .o_axi_rresp(rr), .o_axi_rvalid(rv), .i_axi_rready(rry),
    .i_chan_a_hop_sel_bit0(pins[0]), .i_chan_a_hop_sel_bit1(pins[1]),
    .i_chan_b_hop_sel_bit0(pins[2]), .i_chan_b_hop_sel_bit1(pins[3]),
    .i_sysref(sysref), .i_link_sync_n(lsync_n), .i_link_enable(len),
    .i_sample(smp), .o_chan_a_i(ai), .o_chan_a_q(aq), .o_chan_b_i(bi), .o_chan_b_q(bq),
    .o_chan_a_active(act_a), .o_chan_b_active(act_b), .o_nco_sync(sync));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // handshakes are judged at the falling edge, where they equal the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb_;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wr_r;
      tb_ = bv & bry;
      resp = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb_) bry <= 1'b0;
    end while (!tb_);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(negedge clk);
      ta = arv & arr;
      tr = rv & rry;
      rdat = rdata;
      resp = rr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tr) rry <= 1'b0;
    end while (!tr);
  endtask
  task automatic wact(input logic [1:0] ea, input logic [1:0] eb);
    for (int n = 0; n < 12 && {act_a, act_b} !== {ea, eb}; n++) @(negedge clk);
    chk({act_a, act_b}, {ea, eb});
  endtask
  task automatic wsync();
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 20; n++) begin
      @(negedge clk);
      seen = seen | sync;
    end
    chk(seen, 1'b1);
  endtask
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 6000);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {awv, wv, bry, arv, rry, sysref, len, awa, ara, wd, req} = '0;
    smp = 12'h123;
    lsync_n = 1'b0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(ncobhs_pkg::NCOBHS_CTRL_OFFSET);
    chk(rdat, 32'h0);
    rd(8'h0C);
    chk(resp, ncobhs_pkg::NCOBHS_RESP_SLVERR);
    for (int k = 0; k < 4; k++) begin
      // pins disagree with the field, so a wrongly used source shows up
      req <= {~k[1:0], k[1:0]};
      wr(ncobhs_pkg::NCOBHS_CTRL_OFFSET, {27'h0, k[1:0], ~k[1:0], 1'b0});
      wact(~k[1:0], k[1:0]);
      wr(ncobhs_pkg::NCOBHS_FREQ_A_BASE + 8'(4 * k), 32'hA5C3_0001 << k);
      wr(ncobhs_pkg::NCOBHS_PHASE_B_BASE + 8'(4 * k), 32'hFFFF_1230 + k);
      rd(ncobhs_pkg::NCOBHS_FREQ_A_BASE + 8'(4 * k));
      chk(rdat, 32'hA5C3_0001 << k);
      rd(ncobhs_pkg::NCOBHS_PHASE_B_BASE + 8'(4 * k));
      chk(rdat, 32'h1230 + k);
    end
    wr(ncobhs_pkg::NCOBHS_CTRL_OFFSET, 32'h1);
    for (int k = 0; k < 4; k++) begin
      req <= {~k[1:0], k[1:0]};
      wact(k[1:0], ~k[1:0]);
    end
    wr(ncobhs_pkg::NCOBHS_RDIV_OFFSET, 32'h1);
    rd(ncobhs_pkg::NCOBHS_RDIV_OFFSET);
    chk(rdat, 32'h1);
    repeat (140) @(posedge clk);
    wr(ncobhs_pkg::NCOBHS_RDIV_OFFSET, 32'h0);
    wr(ncobhs_pkg::NCOBHS_CTRL_OFFSET, 32'h41);
    sysref <= 1'b1;
    wsync();
    sysref <= 1'b0;
    rd(ncobhs_pkg::NCOBHS_STATUS_OFFSET);
    chk(rdat[15:4], 12'h010);
    wr(ncobhs_pkg::NCOBHS_CTRL_OFFSET, 32'h21);
    len <= 1'b1;
    repeat (4) @(posedge clk);
    lsync_n <= 1'b1;
    wsync();
    rd(ncobhs_pkg::NCOBHS_STATUS_OFFSET);
    chk(rdat[15:8], 8'h02);
    // channel b words are zero, so its phase is the offset 0x1230 of nco 0
    @(negedge clk);
    chk(bi, 32'h000084FF);
    chk(bq, 32'h000FC84D);
    @(posedge clk);
    smp <= 12'h000;
    repeat (2) @(negedge clk);
    chk(ai, 32'h0);
    chk(aq, 32'h0);
    wrap_up();
  end
endmodule
